// *** usbts_pkg.sv ***
// constants, register map and field layout of the usb transfer status block
// How it works
// - status bits 7..4 hold last endpoint number
// - status bit 3 set for transmit transfers
// - status bit 2 set for odd bank
// - status bits 31..8 and 1..0 read zero
// - status register fronts a four-entry record fifo
// - status valid only while completion flag set
// - clearing completion flag pops the fifo
// - pointer reset bit forces even bank pointers
// - enable bit turns the module on
// - host mode frame tokens every millisecond when enabled
// - host logic reset whenever host bit toggles
// - host appends low-speed eop when resume clears
package usbts_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] STAT_OFS = 12'h000;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h004;
	localparam logic [ADDR_W-1:0] IFLAG_OFS = 12'h008;
	localparam logic [ADDR_W-1:0] TOKEN_OFS = 12'h00C;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_PPRST_BIT = 1;
	localparam int CTRL_RESUME_BIT = 2;
	localparam int CTRL_HOST_BIT = 3;
	localparam int CTRL_FRAME_TOKEN_ENABLE_BIT = 4;
	localparam int CTRL_TOKBUSY_BIT = 5;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam int IFLAG_TRN_BIT = 3;
	localparam int STAT_ENDP_LSB = 4;
	localparam int STAT_DIR_BIT = 3;
	localparam int STAT_ODD_BIT = 2;
	localparam int REC_W = 6;
	localparam int TOKEN_W = 8;
	localparam logic [TOKEN_W-1:0] TOKEN_RESET = 8'h00;
	localparam int FIFO_DEPTH = 4;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOF_PERIOD_NS = 1000000;
	localparam int SOF_PERIOD_CYC = SOF_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// *** usbts_core.sv ***
// usb transfer status fifo, control register and frame timing behind apb
module usbts_core #(
	parameter int DEPTH = usbts_pkg::FIFO_DEPTH,
	parameter int SOF_CYC = usbts_pkg::SOF_PERIOD_CYC
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [usbts_pkg::ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// completed transfer from the usb engine
	input wire logic XFER_DONE,
	input wire logic [3:0] XFER_ENDP,
	input wire logic XFER_TX,
	input wire logic XFER_ODD,
	output logic XFER_READY,
	// token engine
	input wire logic TOKEN_DONE,
	output logic [usbts_pkg::TOKEN_W-1:0] TOKEN_CMD,
	output logic TOKEN_GO,
	// control towards the usb engine
	output logic MODULE_ON,
	output logic PTR_EVEN_FORCE,
	output logic HOST_LOGIC_RESET,
	output logic SOF_TOKEN,
	output logic RESUME_DRIVE,
	output logic LS_EOP,
	output logic TRN_FLAG
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int SOF_W = $clog2(SOF_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [SOF_W-1:0] SOF_LAST = SOF_W'(SOF_CYC - 1);

	logic [usbts_pkg::REC_W-1:0] fifo_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [usbts_pkg::CTRL_W-1:0] ctrl;
	logic host_prev;
	logic resume_prev;
	logic [SOF_W-1:0] sof_cnt;
	logic access;
	logic wr_acc;
	logic push;
	logic pop;
	logic tok_write;
	logic host_on;
	logic [usbts_pkg::REC_W-1:0] head;
	logic [31:0] stat_word;
	logic [31:0] rd_word;
	logic addr_ok;
	logic acc_wait;

	// apb: one wait cycle, everything commits at the pready edge
	assign access = PSEL & PENABLE & PREADY;
	// first access cycle, the one that earns the wait state
	assign acc_wait = PSEL & PENABLE & ~PREADY;
	assign wr_acc = access & PWRITE;
	assign host_on = ctrl[usbts_pkg::CTRL_HOST_BIT];
	assign head = fifo_mem[rd_ptr];

	// record pushed only while the fifo has room
	assign push = XFER_DONE & ctrl[usbts_pkg::CTRL_EN_BIT]
		& (count != CNT_FULL);
	// writing one to the completion flag clears it, which advances
	assign pop = wr_acc & (PADDR == usbts_pkg::IFLAG_OFS)
		& PWDATA[usbts_pkg::IFLAG_TRN_BIT] & (count != '0);
	// token refused while busy so a command is never overwritten
	assign tok_write = wr_acc & (PADDR == usbts_pkg::TOKEN_OFS)
		& ~ctrl[usbts_pkg::CTRL_TOKBUSY_BIT];

	// push and pop in one cycle leave the count alone
	always_comb begin
		next_count = count;
		if (push & ~pop) begin
			next_count = count + CNT_W'(1);
		end else if (pop & ~push) begin
			next_count = count - CNT_W'(1);
		end
	end

	// status record fields; zero while no record is held
	always_comb begin
		stat_word = 32'h0000_0000;
		if (count != '0) begin
			stat_word[usbts_pkg::STAT_ENDP_LSB +: 4] = head[5:2];
			stat_word[usbts_pkg::STAT_DIR_BIT] = head[1];
			stat_word[usbts_pkg::STAT_ODD_BIT] = head[0];
		end
	end

	// read mux; offsets outside the map flag a slave error
	always_comb begin
		rd_word = 32'h0000_0000;
		addr_ok = 1'b1;
		case (PADDR)
			usbts_pkg::STAT_OFS: begin
				rd_word = stat_word;
			end
			usbts_pkg::CTRL_OFS: begin
				rd_word[usbts_pkg::CTRL_W-1:0] = ctrl;
			end
			usbts_pkg::IFLAG_OFS: begin
				rd_word[usbts_pkg::IFLAG_TRN_BIT] = TRN_FLAG;
			end
			usbts_pkg::TOKEN_OFS: begin
				rd_word[usbts_pkg::TOKEN_W-1:0] = TOKEN_CMD;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// ready rises one cycle after enable: a single wait state
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= acc_wait;
		end
	end

	// unmapped offsets answer with an error and no effect
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PSLVERR <= 1'b0;
		end else begin
			PSLVERR <= acc_wait & ~addr_ok;
		end
	end

	// read data only in the ready cycle, zero between
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (acc_wait & ~PWRITE) begin
			PRDATA <= rd_word;
		end else begin
			PRDATA <= 32'h0000_0000;
		end
	end

	// record fifo
	// memory is not reset; an empty fifo reads as zero anyway
	always_ff @(posedge REF_CLK) begin
		if (push) begin
			fifo_mem[wr_ptr] <= {XFER_ENDP, XFER_TX, XFER_ODD};
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_W'(1);
		end
	end

	// count is the single source of full and empty
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// flags follow the next count so they never lag a push or pop
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TRN_FLAG <= 1'b0;
			XFER_READY <= 1'b0;
		end else begin
			// a push in the clearing cycle keeps the flag up
			TRN_FLAG <= (next_count != '0);
			XFER_READY <= (next_count != CNT_FULL);
		end
	end

	// control register; busy bit is hardware owned, set wins over done
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl <= usbts_pkg::CTRL_RESET;
		end else begin
			if (wr_acc & (PADDR == usbts_pkg::CTRL_OFS)) begin
				ctrl[usbts_pkg::CTRL_TOKBUSY_BIT-1:0] <=
					PWDATA[usbts_pkg::CTRL_TOKBUSY_BIT-1:0];
			end
			if (tok_write) begin
				ctrl[usbts_pkg::CTRL_TOKBUSY_BIT] <= 1'b1;
			end else if (TOKEN_DONE) begin
				ctrl[usbts_pkg::CTRL_TOKBUSY_BIT] <= 1'b0;
			end
		end
	end

	// go pulses once per accepted command
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TOKEN_GO <= 1'b0;
		end else begin
			TOKEN_GO <= tok_write;
		end
	end

	// command held for the engine until the next accepted one
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			TOKEN_CMD <= usbts_pkg::TOKEN_RESET;
		end else if (tok_write) begin
			TOKEN_CMD <= PWDATA[usbts_pkg::TOKEN_W-1:0];
		end
	end

	// level controls mirrored from the control register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			MODULE_ON <= 1'b0;
		end else begin
			MODULE_ON <= ctrl[usbts_pkg::CTRL_EN_BIT];
		end
	end

	// pointers stay forced for as long as the bit is held
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			PTR_EVEN_FORCE <= 1'b0;
		end else begin
			PTR_EVEN_FORCE <= ctrl[usbts_pkg::CTRL_PPRST_BIT];
		end
	end

	// resume length is timed by software, not here
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			RESUME_DRIVE <= 1'b0;
		end else begin
			RESUME_DRIVE <= ctrl[usbts_pkg::CTRL_RESUME_BIT];
		end
	end

	// host reset pulse on either edge of the host bit
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			host_prev <= 1'b0;
			HOST_LOGIC_RESET <= 1'b0;
		end else begin
			host_prev <= host_on;
			HOST_LOGIC_RESET <= host_on ^ host_prev;
		end
	end

	// low-speed eop appended when resume drops in host mode
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			resume_prev <= 1'b0;
			LS_EOP <= 1'b0;
		end else begin
			resume_prev <= ctrl[usbts_pkg::CTRL_RESUME_BIT];
			LS_EOP <= host_on & resume_prev
				& ~ctrl[usbts_pkg::CTRL_RESUME_BIT];
		end
	end

	// frame timer restarts on host toggle so frames realign
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			sof_cnt <= '0;
			SOF_TOKEN <= 1'b0;
		end else begin
			SOF_TOKEN <= 1'b0;
			if (!host_on || !ctrl[usbts_pkg::CTRL_FRAME_TOKEN_ENABLE_BIT]
				|| (host_on ^ host_prev)) begin
				sof_cnt <= '0;
			end else if (sof_cnt == SOF_LAST) begin
				sof_cnt <= '0;
				SOF_TOKEN <= 1'b1;
			end else begin
				sof_cnt <= sof_cnt + SOF_W'(1);
			end
		end
	end
endmodule

// *** usbts_props.sv ***
// assertions on the ports of the usb transfer status block
module usbts_props #(
	parameter int SOF_CYC = 20
) (
	// clock, reset and apb
	input wire logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA, PRDATA,
	// transfer and control side
	input wire logic XFER_DONE, XFER_READY, TRN_FLAG, MODULE_ON,
	input wire logic PTR_EVEN_FORCE, RESUME_DRIVE, HOST_LOGIC_RESET,
	input wire logic SOF_TOKEN, LS_EOP
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	wire rd = PSEL && PENABLE && PREADY && !PWRITE;
	wire wr = PSEL && PENABLE && PREADY && PWRITE;
	// cycles since the last frame token, 0 before the first
	logic [31:0] gap;
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) gap <= 32'h0;
		else if (SOF_TOKEN) gap <= 32'h1;
		else if (gap != 32'h0) gap <= gap + 32'h1;
	end
	stat_bits_a: assert property (rd && PADDR == 12'h000
		|-> PRDATA[31:8] == 24'h0 && PRDATA[1:0] == 2'h0) else $error("bits");
	stat_empty_a: assert property (rd && PADDR == 12'h000 && !TRN_FLAG
		|-> PRDATA == 32'h0) else $error("empty status");
	ctrl_out_a: assert property (wr && PADDR == 12'h004 |-> ##2
		{RESUME_DRIVE, PTR_EVEN_FORCE, MODULE_ON} == $past(PWDATA[2:0], 2))
		else $error("control outputs");
	push_flag_a: assert property (XFER_DONE && XFER_READY && MODULE_ON
		|=> TRN_FLAG) else $error("push");
	full_flag_a: assert property ($past(NRST) && !XFER_READY
		|-> TRN_FLAG) else $error("full");
	flag_pop_a: assert property ($fell(TRN_FLAG)
		|-> $past(wr && PADDR == 12'h008)) else $error("pop");
	host_pulse_a: assert property (HOST_LOGIC_RESET
		|=> !HOST_LOGIC_RESET) else $error("host reset");
	eop_pulse_a: assert property (LS_EOP |=> !LS_EOP)
		else $error("eop");
	sof_gap_a: assert property (SOF_TOKEN
		|-> gap == 32'h0 || gap >= SOF_CYC) else $error("sof gap");
	cover property (rd && TRN_FLAG);
	cover property (XFER_DONE && !XFER_READY);
	cover property (LS_EOP);
endmodule

// *** usbts_engine_model.sv ***
// far-side usb engine: reports transfers, finishes tokens
module usbts_engine_model (
	// clock and pacing
	input wire logic clk,
	input wire logic [3:0] lag,
	// token handshake
	input wire logic token_go,
	output logic token_done,
	// transfer report
	output logic done,
	output logic [3:0] endp,
	output logic tx,
	output logic odd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		token_done = 1'b0;
		done = 1'b0;
		{endp, tx, odd} = 6'h00;
	end
	always @(posedge clk) begin
		if (token_go) begin
			repeat (lag) @(posedge clk);
			token_done <= 1'b1;
			@(posedge clk);
			token_done <= 1'b0;
		end
	end
	task automatic put(input logic [5:0] r);
		done <= 1'b1;
		{endp, tx, odd} <= r;
		@(posedge clk);
	endtask
	// released fields show garbage, not the old record
	task automatic stop();
		done <= 1'b0;
		{endp, tx, odd} <= ~{endp, tx, odd};
	endtask
endmodule

// *** test_usb_transfer_status_and_control.sv ***
// self-checking bench for the usb transfer status block
module test_usb_transfer_status_and_control;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SOF_CYC = 20;
	localparam logic [32:0] ALL = '1;
	localparam logic [32:0] EN = 33'h1;
	localparam logic [11:0] CT = usbts_pkg::CTRL_OFS;
	localparam logic [11:0] TK = usbts_pkg::TOKEN_OFS;
	logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rdat;
	logic XFER_DONE, XFER_TX, XFER_ODD, XFER_READY, TOKEN_DONE, TOKEN_GO;
	logic [3:0] XFER_ENDP, lag;
	logic [7:0] TOKEN_CMD;
	logic MODULE_ON, PTR_EVEN_FORCE, HOST_LOGIC_RESET, SOF_TOKEN;
	logic RESUME_DRIVE, LS_EOP, TRN_FLAG;
	logic [65:0] q[$];
	logic [65:0] e;
	logic [5:0] rec[5];
	int seed = 56896;
	int error_cnt = 0;
	int checked = 0;
	int sof_n = 0, eop_n = 0, hrst_n = 0;
	int i;
	usbts_core #(.SOF_CYC(SOF_CYC)) usbts_core_i (.*);
	usbts_engine_model usbts_engine_model_i (.clk(REF_CLK), .lag(lag),
		.token_go(TOKEN_GO), .token_done(TOKEN_DONE), .done(XFER_DONE),
		.endp(XFER_ENDP), .tx(XFER_TX), .odd(XFER_ODD));
	initial begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	task automatic chk(input string n, input logic [31:0] x, y);
		checked++;
		if (y !== x) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", n, x, y);
		end
	endtask
	// reads note {mask, error, data}; the monitor compares
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [32:0] d, m);
		int n;
		if (!w) q.push_back({m, d});
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d[31:0];
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do @(posedge REF_CLK);
		while (PREADY !== 1'b1 && ++n < 20);
		rdat = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	always @(posedge REF_CLK) begin
		sof_n += (SOF_TOKEN === 1'b1);
		eop_n += (LS_EOP === 1'b1);
		hrst_n += (HOST_LOGIC_RESET === 1'b1);
		if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
			e = q.pop_front();
			chk("read", e[31:0] & e[64:33], PRDATA & e[64:33]);
			chk("slverr", e[32] & e[65], PSLVERR & e[65]);
		end
	end
	task automatic finish_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge REF_CLK);
		error_cnt++;
		finish_test();
	end
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		lag = 4'h0;
		NRST = 1'b0;
		repeat (3) @(posedge REF_CLK);
		NRST <= 1'b1;
		bus(0, usbts_pkg::STAT_OFS, 33'h0, ALL);
		bus(0, CT, 33'h0, ALL);
		bus(0, 12'h010, 33'h1_0000_0000, ALL);
		bus(1, CT, EN, 33'h0);
		rec[0] = 6'h3F;
		rec[1] = 6'h00;
		for (i = 2; i < 5; i++) rec[i] = 6'($random(seed));
		for (i = 0; i < 5; i++) usbts_engine_model_i.put(rec[i]);
		usbts_engine_model_i.stop();
		@(posedge REF_CLK);
		chk("ready", 0, XFER_READY);
		for (i = 0; i < 4; i++) begin
			bus(0, 12'h000, {25'h0, rec[i], 2'h0}, ALL);
			bus(1, usbts_pkg::IFLAG_OFS, 33'h8, 33'h0);
		end
		bus(0, usbts_pkg::STAT_OFS, 33'h0, ALL);
		bus(1, CT, 33'h7, 33'h0);
		bus(1, CT, 33'h1D, 33'h0);
		repeat (5 * SOF_CYC + 5) @(posedge REF_CLK);
		bus(1, CT, 33'h9, 33'h0);
		bus(1, CT, EN, 33'h0);
		repeat (3) @(posedge REF_CLK);
		chk("sof", 5, sof_n);
		chk("eop", 1, eop_n);
		chk("host", 2, hrst_n);
		lag = 4'hA;
		bus(1, TK, 33'hA5, 33'h0);
		bus(1, TK, 33'h11, 33'h0);
		bus(0, CT, 33'h21, ALL);
		chk("token", 8'hA5, TOKEN_CMD);
		do bus(0, CT, 33'h0, 33'h0);
		while (rdat[usbts_pkg::CTRL_TOKBUSY_BIT]);
		lag = 4'h0;
		bus(1, TK, 33'h3C, 33'h0);
		@(posedge REF_CLK);
		chk("token", 8'h3C, TOKEN_CMD);
		finish_test();
	end
endmodule
bind usbts_core usbts_props #(.SOF_CYC(SOF_CYC)) usbts_props_i (.*);
